/* File: pkg/bfc_pkg.sv */
// Purpose: Shared constants and types of the brake contactor feedback check
// Assumes: Seven general inputs, one feedback selection digit
// Notes: A digit is sampled once after reset release and then held
package bfc_pkg;

  // General input circuits on the connector
  localparam int BFC_NUM_INPUTS = 7;

  // Selection digit encodings
  localparam logic [3:0] BFC_DIGIT_CLOSED_FIRST = 4'h0;
  localparam logic [3:0] BFC_DIGIT_CLOSED_LAST = 4'h6;
  localparam logic [3:0] BFC_DIGIT_RESERVED = 4'h7;
  localparam logic [3:0] BFC_DIGIT_DISABLED = 4'h8;
  localparam logic [3:0] BFC_DIGIT_OPEN_FIRST = 4'h9;
  localparam logic [3:0] BFC_DIGIT_OPEN_LAST = 4'hf;

  // Position of the feedback digit in the assignment parameter
  localparam int BFC_DIGIT_POS = 2;
  localparam int BFC_DIGIT_LSB = BFC_DIGIT_POS * 4;

  // Factory value of the whole assignment parameter
  localparam logic [15:0] BFC_ASSIGN_RESET = 16'h0800;

  // Clock and feedback filter time
  localparam int BFC_CLK_PERIOD_NS = 10;
  localparam int BFC_FILTER_TIME_NS = 40;
  localparam int BFC_FILTER_CYCLES =
    (BFC_FILTER_TIME_NS + BFC_CLK_PERIOD_NS - 1) / BFC_CLK_PERIOD_NS;

  // Decoded feedback configuration
  typedef struct packed {
    logic enable;
    logic faultOnOpen;
    logic [2:0] index;
  } bfc_cfg_t;

  localparam bfc_cfg_t BFC_CFG_RESET = '{enable: 1'b0, faultOnOpen: 1'b0,
                                         index: 3'h0};

  typedef enum logic [1:0] {
    BFC_ST_OFF = 2'b00,
    BFC_ST_WATCH = 2'b01,
    BFC_ST_FAULT = 2'b10
  } bfc_state_t;

endpackage

/* File: src/bfc_brake_feedback_check.sv */
// Purpose: Flags contactor welding or failure to operate from the
//   auxiliary contact feedback while the dynamic brake is applied
// Assumes: All inputs synchronous to clk; input high means closed
// Notes: The setting is caught once per reset; the alarm is sticky
// Operation
// - Feedback choice from third parameter digit.
// - Digits 0-6: inputs 1-7, closed faults.
// - Digits 9-F: inputs 1-7, open faults.
// - Digit 8 disables detection; factory default.
// - Functions sharing an input are ORed.
`timescale 1ns/1ns
module bfc_brake_feedback_check
  import bfc_pkg::*;
#(
  parameter int NUM_INPUTS = BFC_NUM_INPUTS,
  parameter int FILTER_CYCLES = BFC_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Setting, sampled once after reset release
  input wire logic [15:0] inputAssignmentParameter,
  // General input connector pins, high is closed
  input wire logic [NUM_INPUTS-1:0] generalInputConnector,
  // Other functions driving the same input circuits
  input wire logic [NUM_INPUTS-1:0] sharedCircuitDrive,
  // Dynamic brake state
  input wire logic dynamicBrakeApplied,
  // Alarm reset from the drive
  input wire logic alarmClear,
  // Results
  output logic [NUM_INPUTS-1:0] inputCircuitActive,
  output logic brakeFeedbackInput,
  output logic contactorError,
  output logic contactorErrorPulse,
  output logic detectionEnabled
);

  // The digit decode only reaches seven inputs; the filter counter is 8 bits
  if (NUM_INPUTS != BFC_NUM_INPUTS) begin : g_bad_inputs
    $error("NUM_INPUTS must equal the digit decode range");
  end
  if (FILTER_CYCLES < 1 || FILTER_CYCLES > 255) begin : g_bad_filter
    $error("FILTER_CYCLES must lie in 1..255");
  end

  localparam logic [7:0] FILTER_LAST = 8'(FILTER_CYCLES - 1);

  bfc_cfg_t cfg_reg;
  bfc_cfg_t cfg_next;
  logic cfgLoaded_reg;
  logic [3:0] digit;
  logic [NUM_INPUTS-1:0] circuit_reg;
  logic selected;
  logic faultLevel;
  logic [7:0] filter_reg;
  logic faultConfirm;
  bfc_state_t state_reg;
  bfc_state_t state_next;

  // Digit decode
  assign digit = inputAssignmentParameter[BFC_DIGIT_LSB +: 4];

  always_comb begin
    cfg_next = BFC_CFG_RESET;
    if (digit <= BFC_DIGIT_CLOSED_LAST) begin
      cfg_next.enable = 1'b1;
      cfg_next.faultOnOpen = 1'b0;
      cfg_next.index = 3'(digit - BFC_DIGIT_CLOSED_FIRST);
    end else if (digit >= BFC_DIGIT_OPEN_FIRST) begin
      cfg_next.enable = 1'b1;
      cfg_next.faultOnOpen = 1'b1;
      cfg_next.index = 3'(digit - BFC_DIGIT_OPEN_FIRST);
    end else begin
      // Digit 8 and the reserved digit 7 both leave detection off
      cfg_next.enable = 1'b0;
    end
  end

  // The setting only takes effect after a restart, so it is caught once
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg <= BFC_CFG_RESET;
      cfgLoaded_reg <= 1'b0;
    end else if (!cfgLoaded_reg) begin
      cfg_reg <= cfg_next;
      cfgLoaded_reg <= 1'b1;
    end
  end

  // Input circuits: any function mapped to a circuit operates it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      circuit_reg <= '0;
    end else begin
      circuit_reg <= generalInputConnector | sharedCircuitDrive;
    end
  end

  assign selected = circuit_reg[cfg_reg.index];
  assign faultLevel = cfgLoaded_reg && cfg_reg.enable && dynamicBrakeApplied
                      && (selected == !cfg_reg.faultOnOpen);

  // A fault must persist FILTER_CYCLES cycles before the alarm is raised
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      filter_reg <= 8'h00;
    end else if (!faultLevel) begin
      filter_reg <= 8'h00;
    end else if (filter_reg != FILTER_LAST) begin
      filter_reg <= filter_reg + 8'h01;
    end
  end

  assign faultConfirm = faultLevel && (filter_reg == FILTER_LAST);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BFC_ST_OFF: begin
        if (cfgLoaded_reg && cfg_reg.enable) begin
          state_next = BFC_ST_WATCH;
        end
      end
      BFC_ST_WATCH: begin
        if (faultConfirm) begin
          state_next = BFC_ST_FAULT;
        end
      end
      BFC_ST_FAULT: begin
        // A fault present in the clear cycle keeps the alarm
        if (alarmClear && !faultConfirm) begin
          state_next = BFC_ST_WATCH;
        end
      end
      default: begin
        state_next = BFC_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= BFC_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      contactorError <= 1'b0;
      contactorErrorPulse <= 1'b0;
    end else begin
      contactorError <= (state_next == BFC_ST_FAULT);
      contactorErrorPulse <= (state_reg == BFC_ST_WATCH) && faultConfirm;
    end
  end

  assign inputCircuitActive = circuit_reg;
  assign brakeFeedbackInput = cfg_reg.enable & selected;
  assign detectionEnabled = cfg_reg.enable;

  // Checks
  a_closed_decode: assert property (@(posedge clk)
    disable iff (!reset_n)
    $rose(cfgLoaded_reg) && $past(digit) <= BFC_DIGIT_CLOSED_LAST
    |-> cfg_reg.enable && !cfg_reg.faultOnOpen
        && cfg_reg.index == 3'($past(digit)))
    else $error("closed digit decoded wrongly");

  a_open_decode: assert property (@(posedge clk)
    disable iff (!reset_n)
    $rose(cfgLoaded_reg) && $past(digit) >= BFC_DIGIT_OPEN_FIRST
    |-> cfg_reg.enable && cfg_reg.faultOnOpen
        && cfg_reg.index == 3'($past(digit) - BFC_DIGIT_OPEN_FIRST))
    else $error("open digit decoded wrongly");

  a_off_digits: assert property (@(posedge clk)
    disable iff (!reset_n)
    $rose(cfgLoaded_reg) && ($past(digit) == BFC_DIGIT_DISABLED
      || $past(digit) == BFC_DIGIT_RESERVED)
    |-> !cfg_reg.enable)
    else $error("digit 7 or 8 left detection on");

  a_never_off: assert property (@(posedge clk)
    disable iff (!reset_n)
    !cfg_reg.enable |-> !contactorError && !contactorErrorPulse
      && !brakeFeedbackInput)
    else $error("alarm raised while detection off");

  a_cfg_held: assert property (@(posedge clk)
    disable iff (!reset_n)
    cfgLoaded_reg && $past(cfgLoaded_reg) |-> $stable(cfg_reg))
    else $error("setting changed without restart");

  a_shared_or: assert property (@(posedge clk)
    disable iff (!reset_n)
    1'b1 |=> circuit_reg == $past(generalInputConnector | sharedCircuitDrive))
    else $error("input circuit not the OR of its sources");

  a_fault_raise: assert property (@(posedge clk)
    disable iff (!reset_n)
    state_reg == BFC_ST_WATCH && faultLevel && filter_reg == FILTER_LAST
    |=> contactorError && contactorErrorPulse)
    else $error("confirmed fault not flagged");

  a_no_release: assert property (@(posedge clk)
    disable iff (!reset_n)
    !dynamicBrakeApplied && !contactorError |=> !contactorError)
    else $error("alarm raised with brake released");

  a_pulse_single: assert property (@(posedge clk)
    disable iff (!reset_n)
    contactorErrorPulse |=> !contactorErrorPulse)
    else $error("alarm pulse longer than one cycle");

  // A clear that meets a standing fault must lose to it
  a_clear_blocked: assert property (@(posedge clk)
    disable iff (!reset_n)
    contactorError && alarmClear && faultConfirm |=> contactorError)
    else $error("clear dropped a standing fault");

  a_clear_done: assert property (@(posedge clk)
    disable iff (!reset_n)
    contactorError && alarmClear && !faultConfirm |=> !contactorError)
    else $error("clear ignored with no fault present");

  c_closed_fault: cover property (@(posedge clk) disable iff (!reset_n)
    contactorErrorPulse && !cfg_reg.faultOnOpen);
  c_open_fault: cover property (@(posedge clk) disable iff (!reset_n)
    contactorErrorPulse && cfg_reg.faultOnOpen);
  c_clear: cover property (@(posedge clk) disable iff (!reset_n)
    contactorError ##1 !contactorError);
  c_clear_blocked: cover property (@(posedge clk) disable iff (!reset_n)
    contactorError && alarmClear ##1 contactorError);

endmodule

/* File: test/bfc_aux_contact_model.sv */
// Purpose: Auxiliary contact of the external dynamic brake contactor
// Assumes: Contact follows the brake with no bounce
// Notes: faultMode 1 welds it closed, 2 leaves it open
`timescale 1ns/1ns
module bfc_aux_contact_model (
  // Contactor drive and contact type
  input wire logic dynamicBrakeApplied,
  input wire logic ncContact,
  // Injected fault
  input wire logic [1:0] faultMode,
  // Contact state, high is closed
  output logic contactClosed
);
  always_comb begin
    if (faultMode == 2'h1) contactClosed = 1'b1;
    else if (faultMode == 2'h2) contactClosed = 1'b0;
    else contactClosed = dynamicBrakeApplied ^ ncContact;
  end
endmodule

/* File: test/tb_brake_contactor_feedback_check.sv */
// Purpose: Self-checking bench of the contactor feedback check
// Assumes: Inputs driven at the falling edge
// Notes: Every digit once, then random digits
`timescale 1ns/1ns
module tb_brake_contactor_feedback_check;
  import bfc_pkg::*;
  localparam int FILT = 2;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] cfgWord = 16'h0000;
  logic [6:0] otherPins = 7'h00;
  logic [6:0] shared = 7'h00;
  logic [6:0] pins, act;
  logic brake = 1'b0, clr = 1'b0, nc = 1'b0;
  logic contact, fbIn, err, errPulse, detEn;
  logic [1:0] fault = 2'h0;
  logic [2:0] idx = 3'h0;
  int mismatches = 0, comparisons = 0, cycles = 0;
  int seed = 32'h68adfc84;
  always #5 clk = ~clk;
  always_comb begin
    pins = otherPins;
    pins[idx] = contact;
  end
  bfc_aux_contact_model partner (.dynamicBrakeApplied(brake),
    .ncContact(nc), .faultMode(fault), .contactClosed(contact));
  bfc_brake_feedback_check #(.NUM_INPUTS(7), .FILTER_CYCLES(FILT)) DUT (
    .clk(clk), .reset_n(reset_n), .inputAssignmentParameter(cfgWord),
    .generalInputConnector(pins), .sharedCircuitDrive(shared),
    .dynamicBrakeApplied(brake), .alarmClear(clr),
    .inputCircuitActive(act), .brakeFeedbackInput(fbIn),
    .contactorError(err), .contactorErrorPulse(errPulse),
    .detectionEnabled(detEn));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [6:0] e, g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic waitN(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Healthy contact first, then a fault, clear, and the OR masking case
  task automatic run(input logic [3:0] d);
    logic en, open;
    en = (d != BFC_DIGIT_RESERVED) && (d != BFC_DIGIT_DISABLED);
    open = d >= BFC_DIGIT_OPEN_FIRST;
    reset_n = 1'b0;
    idx = !en ? 3'h0 : open ? 3'(d - BFC_DIGIT_OPEN_FIRST) : d[2:0];
    nc = ~open;
    fault = 2'h0;
    brake = 1'b1;
    cfgWord = 16'($random(seed));
    cfgWord[BFC_DIGIT_LSB +: 4] = d;
    otherPins = 7'($random(seed));
    shared = 7'($random(seed));
    shared[idx] = 1'b0;
    waitN(2);
    reset_n = 1'b1;
    waitN(FILT + 4);
    chk("enable", 7'(en), 7'(detEn));
    chk("healthy", 7'h00, 7'(err));
    chk("circuit", pins | shared, act);
    chk("feedback", 7'(en & pins[idx]), 7'(fbIn));
    fault = open ? 2'h2 : 2'h1;
    // Alarm lands FILT edges after the circuit register sees the fault
    waitN(FILT);
    chk("early", 7'h00, 7'(err));
    waitN(1);
    chk("pulse", 7'(en), 7'(errPulse));
    chk("fault", 7'(en), 7'(err));
    // A clear while the fault persists must not drop the alarm
    clr = 1'b1;
    waitN(1);
    chk("pulseEnd", 7'h00, 7'(errPulse));
    chk("clrHeld", 7'(en), 7'(err));
    brake = 1'b0;
    waitN(2);
    clr = 1'b0;
    waitN(FILT + 3);
    chk("released", 7'h00, 7'(err));
    // Shared drive closes the circuit whatever the contact does
    fault = open ? 2'h2 : 2'h0;
    shared[idx] = 1'b1;
    brake = 1'b1;
    waitN(FILT + 3);
    chk("orFault", 7'(en & ~open), 7'(err));
    $display("digit %h done", d);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    for (int d = 0; d < 16; d++) run(4'(d));
    repeat (6) run(4'($random(seed)));
    conclude();
  end
endmodule
